// File: rtl/phdp_pkg.sv
// constants shared by the power-line host data port
// assumes a core clock plus a reference clock supplied at the port
package phdp_pkg;

  // interface mode straps, in strap order
  localparam logic [2:0] MODE_MII  = 3'h1;
  localparam logic [2:0] MODE_RMII = 3'h2;
  localparam logic [2:0] MODE_FIFO = 3'h3;

  // strobe must be seen low this many reference cycles
  localparam logic [1:0] STROBE_MIN = 2'h3;

  // buffer sizes in bytes
  localparam int TX_BUF_BYTES = 2048;
  localparam int RX_BUF_BYTES = 2048;

  // interframe gap and decode hold, in reference clock cycles
  localparam int IFG_CYC         = 24;
  localparam int DECODE_HOLD_CYC = 8;

  // reduced-pin di-bit codes
  localparam logic [1:0] DIBIT_IDLE = 2'h0;
  localparam logic [1:0] DIBIT_ERR  = 2'h2;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_GAP,
    RX_SEND,
    RX_DONE
  } phdp_rx_state_t;

endpackage : phdp_pkg

// File: rtl/phdp_top.sv
// host data port: byte-port and reduced-pin link side plus core handshake
// assumes port pins are timed by portRefClock, modem side by clk
//
// Operation
// - errored receive di-bits become 10 till end
// - receive di-bits held 00 until decoding
// - transmit accepted even while receive runs
// - tx-in-progress rises on enable, falls when drained
// - eight-bit bidirectional bus, byte per transfer
// - write strobe rising edge stores one byte
// - chip select high floats port outputs in byte-port mode; reduced-pin mode keeps status driven
// - data bus driven only on select and read
// - two kilobyte transmit buffer allows cut-through
// - separate two kilobyte receive buffer
// - receive valid after gap, never rises during transmit
// - one byte per read edge, valid drops after
// - first two bytes give length, MSB first
// - receive error output flags errored frames in byte-port mode only
// - strobe valid only if low three clocks
// - three straps choose interface mode
`timescale 1ns/1ns
module phdp_top #(
  parameter int TX_DEPTH    = phdp_pkg::TX_BUF_BYTES,
  parameter int RX_DEPTH    = phdp_pkg::RX_BUF_BYTES,
  parameter int IFG         = phdp_pkg::IFG_CYC,
  parameter int DECODE_HOLD = phdp_pkg::DECODE_HOLD_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       portRefClock,
  input  wire logic [2:0] modeStrap,
  input  wire logic       chipSelectN,
  input  wire logic       readStrobeN,
  input  wire logic       writeStrobeN,
  input  wire logic       hostTxEnable,
  input  wire logic [7:0] hostWriteByte,
  output logic      [7:0] hostReadByte,
  output logic            hostDataBusOe,
  output logic            txInProgress,
  output logic            rxDataValid,
  output logic            rxErrorFlag,
  output logic            statusOe,
  input  wire logic [1:0] rmiiTxd,
  input  wire logic       rmiiTxEn,
  output logic      [1:0] rmiiRxd,
  output logic      [7:0] modemTxByte,
  output logic            modemTxLast,
  output logic            modemTxValid,
  input  wire logic       modemTxReady,
  input  wire logic [7:0] modemRxByte,
  input  wire logic       modemRxLast,
  input  wire logic       modemRxError,
  input  wire logic       modemRxValid,
  output logic            modemRxReady
);

  localparam int TAW = $clog2(TX_DEPTH);
  localparam int RAW = $clog2(RX_DEPTH);
  localparam logic [TAW:0] TX_ONE  = (TAW+1)'(1);
  localparam logic [TAW:0] TX_FULL = (TAW+1)'(TX_DEPTH);
  localparam logic [RAW:0] RX_FULL = (RAW+1)'(RX_DEPTH);
  localparam logic [15:0]  IFG_END = 16'(IFG - 1);
  localparam logic [15:0]  HOLD_N  = 16'(DECODE_HOLD);

  // ---------------- link domain: reset and pin synchronisers ----------------
  logic        lrstS1_r, lrst_n;
  logic [17:0] pinS1_r, pinS2_r;
  logic [2:0]  strapS;
  logic [1:0]  rmTxdS;
  logic        rmTxEnS, txEnS, csLow, rdLow, wrLow;
  logic [7:0]  byteS;

  // reset release is brought into the reference clock domain
  always_ff @(posedge portRefClock) begin
    lrstS1_r <= rst_n;
    lrst_n   <= lrstS1_r;
  end

  // every pin passes two flops before use
  always_ff @(posedge portRefClock) begin
    pinS1_r <= {modeStrap, rmiiTxd, rmiiTxEn, hostTxEnable, hostWriteByte,
                writeStrobeN, readStrobeN, chipSelectN};
    pinS2_r <= pinS1_r;
  end

  assign strapS  = pinS2_r[17:15];
  assign rmTxdS  = pinS2_r[14:13];
  assign rmTxEnS = pinS2_r[12];
  assign txEnS   = pinS2_r[11];
  assign byteS   = pinS2_r[10:3];
  assign wrLow   = !pinS2_r[2];
  assign rdLow   = !pinS2_r[1];
  assign csLow   = !pinS2_r[0];

  // ---------------- mode straps ----------------
  logic [2:0] mode_r;
  logic       modeDone_r, fifoMode, rmiiMode;

  // straps are caught once, on the first edge after reset release
  always_ff @(posedge portRefClock) begin
    if (!lrst_n) begin
      mode_r     <= 3'h0;
      modeDone_r <= 1'b0;
    end else if (!modeDone_r) begin
      mode_r     <= strapS;
      modeDone_r <= 1'b1;
    end
  end

  assign fifoMode = modeDone_r && (mode_r == phdp_pkg::MODE_FIFO);
  assign rmiiMode = modeDone_r && (mode_r == phdp_pkg::MODE_RMII);

  // ---------------- strobe qualification ----------------
  logic [1:0] lowCnt_r [2];
  logic [1:0] stbPrev_r;
  logic [1:0] stbLow, stbRise;
  logic       rdRise, wrRise;
  logic [7:0] wrData_r;

  assign stbLow = {wrLow, rdLow};

  // a short glitch low never counts as an access
  always_ff @(posedge portRefClock) begin
    for (int i = 0; i < 2; i++) begin
      stbPrev_r[i] <= stbLow[i];
      if (!stbLow[i]) lowCnt_r[i] <= 2'h0;
      else if (lowCnt_r[i] != 2'h3) lowCnt_r[i] <= lowCnt_r[i] + 2'h1;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_rise
    assign stbRise[g] = stbPrev_r[g] && !stbLow[g] &&
                        (lowCnt_r[g] >= phdp_pkg::STROBE_MIN);
  end
  assign rdRise = stbRise[0];
  assign wrRise = stbRise[1];

  // data seen while the strobe was still low; host hold time is short
  always_ff @(posedge portRefClock) begin
    wrData_r <= byteS;
  end

  // ---------------- transmit buffer fill ----------------
  logic [7:0]   txMem [TX_DEPTH];
  logic [TAW:0] txWp_r, txRp_r, txFill;
  logic [7:0]   dibSh_r, wrByte;
  logic [1:0]   dibCnt_r;
  logic         wantWr, doWr, txSrcEn, txSrcPrev_r;

  assign txSrcEn = fifoMode ? txEnS : (rmiiMode && rmTxEnS);
  assign txFill  = txWp_r - txRp_r;
  assign wantWr  = fifoMode ? (wrRise && csLow && txEnS)
                            : (rmiiMode && rmTxEnS && dibCnt_r == 2'h3);
  assign wrByte  = fifoMode ? wrData_r : {rmTxdS, dibSh_r[7:2]};
  assign doWr    = wantWr && (txFill != TX_FULL);

  // reduced-pin di-bits gather LSB first into bytes
  always_ff @(posedge portRefClock) begin
    if (!lrst_n || !rmTxEnS) begin
      dibCnt_r <= 2'h0;
      dibSh_r  <= 8'h00;
    end else begin
      dibCnt_r <= dibCnt_r + 2'h1;
      dibSh_r  <= {rmTxdS, dibSh_r[7:2]};
    end
  end

  always_ff @(posedge portRefClock) begin
    if (doWr) txMem[txWp_r[TAW-1:0]] <= wrByte;
  end

  // ---------------- transmit drain toward the modem ----------------
  logic       txReqT_r, txAckS1_r, txAckS2_r, txAckT_r;
  logic [8:0] txWord_r;
  logic       txBusy, canSend;

  assign txBusy  = txReqT_r != txAckS2_r;
  // hold back the last byte until enable drops so it can be marked last
  assign canSend = !txBusy && (txFill != '0) &&
                   ((txFill > TX_ONE) || !txSrcEn);

  always_ff @(posedge portRefClock) begin
    txAckS1_r <= txAckT_r;
    txAckS2_r <= txAckS1_r;
  end

  always_ff @(posedge portRefClock) begin
    if (!lrst_n) begin
      txWp_r   <= '0;
      txRp_r   <= '0;
      txReqT_r <= 1'b0;
      txWord_r <= 9'h000;
    end else begin
      if (doWr) txWp_r <= txWp_r + TX_ONE;
      if (canSend) begin
        txWord_r <= {(txFill == TX_ONE) && !txSrcEn, txMem[txRp_r[TAW-1:0]]};
        txReqT_r <= !txReqT_r;
        txRp_r   <= txRp_r + TX_ONE;
      end
    end
  end

  // ---------------- transmit in progress ----------------
  // rises with enable, falls once enable is gone and all bytes handed on
  always_ff @(posedge portRefClock) begin
    if (!lrst_n) begin
      txInProgress <= 1'b0;
      txSrcPrev_r  <= 1'b0;
    end else begin
      txSrcPrev_r <= txSrcEn;
      if (txSrcEn && !txSrcPrev_r) txInProgress <= 1'b1;
      else if (!txSrcEn && txFill == '0 && !txBusy) txInProgress <= 1'b0;
    end
  end

  // ---------------- receive buffer fill from the modem ----------------
  logic [8:0]   rxMem [RX_DEPTH];
  logic [RAW:0] rxWp_r;
  logic         rxReqS1_r, rxReqS2_r, rxAckT_r, rxReqT_r;
  logic [9:0]   rxHold_r;
  logic         rxFrameRdy_r, frameErr_r, rxTake, rxFull, rxDone;

  assign rxFull = rxWp_r == RX_FULL;
  // one frame at a time; the modem is stalled until the host drains it
  assign rxTake = (rxReqS2_r != rxAckT_r) && !rxFrameRdy_r;

  always_ff @(posedge portRefClock) begin
    rxReqS1_r <= rxReqT_r;
    rxReqS2_r <= rxReqS1_r;
  end

  always_ff @(posedge portRefClock) begin
    if (rxTake && !rxFull) rxMem[rxWp_r[RAW-1:0]] <= rxHold_r[8:0];
  end

  // an overflowing frame is truncated and marked bad
  always_ff @(posedge portRefClock) begin
    if (!lrst_n || rxDone) begin
      rxWp_r       <= '0;
      rxFrameRdy_r <= 1'b0;
      frameErr_r   <= 1'b0;
    end else if (rxTake) begin
      if (!rxFull) rxWp_r <= rxWp_r + (RAW+1)'(1);
      if (rxHold_r[8] || rxFull) frameErr_r <= 1'b1;
      if (rxHold_r[9]) rxFrameRdy_r <= 1'b1;
    end
  end

  always_ff @(posedge portRefClock) begin
    if (!lrst_n) rxAckT_r <= 1'b0;
    else if (rxTake) rxAckT_r <= !rxAckT_r;
  end

  // ---------------- receive delivery to the host ----------------
  phdp_pkg::phdp_rx_state_t rxSt_r;
  logic [15:0]  rxLen, rxGap_r, hold_r;
  logic [RAW+1:0] rxIdx_r, nxtIdx;
  logic [1:0]   dib_r;
  logic         errSeen_r, curErr;
  logic [8:0]   curEnt;
  logic [7:0]   nxtByte;

  assign rxLen  = 16'(rxWp_r);
  assign rxDone = rxSt_r == phdp_pkg::RX_DONE;
  assign nxtIdx = rxIdx_r + (RAW+2)'(1);
  assign curEnt = rxMem[rxIdx_r[RAW-1:0]];
  assign curErr = errSeen_r || curEnt[8];

  // byte-port stream: length MSB, length LSB, then the payload
  always_comb begin
    if (nxtIdx == '0) nxtByte = rxLen[15:8];
    else if (nxtIdx == (RAW+2)'(1)) nxtByte = rxLen[7:0];
    else nxtByte = rxMem[RAW'(nxtIdx - (RAW+2)'(2))][7:0];
  end

  always_ff @(posedge portRefClock) begin
    if (!lrst_n) begin
      rxSt_r       <= phdp_pkg::RX_IDLE;
      rxGap_r      <= 16'h0000;
      hold_r       <= 16'h0000;
      rxIdx_r      <= '0;
      dib_r        <= 2'h0;
      errSeen_r    <= 1'b0;
      rxDataValid  <= 1'b0;
      rxErrorFlag  <= 1'b0;
      hostReadByte <= 8'h00;
      rmiiRxd      <= phdp_pkg::DIBIT_IDLE;
    end else begin
      case (rxSt_r)
        phdp_pkg::RX_IDLE: begin
          rxGap_r <= 16'h0000;
          if (rxFrameRdy_r) rxSt_r <= phdp_pkg::RX_GAP;
        end
        phdp_pkg::RX_GAP: begin
          // any transmit activity restarts the gap
          if (txInProgress || txSrcEn) rxGap_r <= 16'h0000;
          else if (rxGap_r != IFG_END) rxGap_r <= rxGap_r + 16'h0001;
          else begin
            rxSt_r       <= phdp_pkg::RX_SEND;
            rxDataValid  <= 1'b1;
            rxErrorFlag  <= fifoMode && frameErr_r;
            rxIdx_r      <= '0;
            dib_r        <= 2'h0;
            hold_r       <= 16'h0000;
            errSeen_r    <= 1'b0;
            hostReadByte <= rxLen[15:8];
            rmiiRxd      <= phdp_pkg::DIBIT_IDLE;
          end
        end
        phdp_pkg::RX_SEND: begin
          if (fifoMode) begin
            if (rdRise && csLow) begin
              if (16'(rxIdx_r) == rxLen + 16'h0001) begin
                rxSt_r      <= phdp_pkg::RX_DONE;
                rxDataValid <= 1'b0;
                rxErrorFlag <= 1'b0;
              end else begin
                rxIdx_r      <= nxtIdx;
                hostReadByte <= nxtByte;
              end
            end
          end else if (hold_r != HOLD_N) begin
            hold_r  <= hold_r + 16'h0001;
            rmiiRxd <= phdp_pkg::DIBIT_IDLE;
          end else if (rxLen == 16'h0000) begin
            rxSt_r      <= phdp_pkg::RX_DONE;
            rxDataValid <= 1'b0;
          end else begin
            errSeen_r <= curErr;
            // once an error shows, the rest of the frame is spoiled
            rmiiRxd   <= curErr ? phdp_pkg::DIBIT_ERR
                                : curEnt[2*dib_r +: 2];
            dib_r     <= dib_r + 2'h1;
            if (dib_r == 2'h3) begin
              if (16'(rxIdx_r) == rxLen - 16'h0001) begin
                rxSt_r <= phdp_pkg::RX_DONE;
              end else begin
                rxIdx_r <= nxtIdx;
              end
            end
          end
        end
        phdp_pkg::RX_DONE: begin
          rxSt_r      <= phdp_pkg::RX_IDLE;
          rxDataValid <= 1'b0;
          rmiiRxd     <= phdp_pkg::DIBIT_IDLE;
        end
        default: rxSt_r <= phdp_pkg::RX_IDLE;
      endcase
    end
  end

  // ---------------- pin enables ----------------
  // enables follow synchronised pins, so they lag the pins by a few clocks
  always_ff @(posedge portRefClock) begin
    if (!lrst_n) begin
      hostDataBusOe <= 1'b0;
      statusOe      <= 1'b0;
    end else begin
      hostDataBusOe <= fifoMode && csLow && rdLow;
      statusOe      <= rmiiMode || (fifoMode && csLow);
    end
  end

  // ---------------- core domain: transmit handshake ----------------
  logic txReqS1_r, txReqS2_r, txSeen_r;

  always_ff @(posedge clk) begin
    txReqS1_r <= txReqT_r;
    txReqS2_r <= txReqS1_r;
  end

  // word is stable in the link domain until it sees the ack toggle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      txSeen_r     <= 1'b0;
      txAckT_r     <= 1'b0;
      modemTxValid <= 1'b0;
      modemTxByte  <= 8'h00;
      modemTxLast  <= 1'b0;
    end else if (modemTxValid) begin
      if (modemTxReady) begin
        modemTxValid <= 1'b0;
        txAckT_r     <= !txAckT_r;
      end
    end else if (txReqS2_r != txSeen_r) begin
      txSeen_r     <= txReqS2_r;
      modemTxValid <= 1'b1;
      modemTxByte  <= txWord_r[7:0];
      modemTxLast  <= txWord_r[8];
    end
  end

  // ---------------- core domain: receive handshake ----------------
  logic rxAckS1_r, rxAckS2_r, rxAcc;

  assign rxAcc = modemRxValid && modemRxReady;

  always_ff @(posedge clk) begin
    rxAckS1_r <= rxAckT_r;
    rxAckS2_r <= rxAckS1_r;
  end

  // ready only when the previous byte has been taken by the link side
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rxReqT_r     <= 1'b0;
      rxHold_r     <= 10'h000;
      modemRxReady <= 1'b0;
    end else begin
      if (rxAcc) begin
        rxHold_r <= {modemRxLast, modemRxError, modemRxByte};
        rxReqT_r <= !rxReqT_r;
      end
      modemRxReady <= !rxAcc && (rxReqT_r == rxAckS2_r);
    end
  end

endmodule : phdp_top

// File: test/phdp_top_asserts.sv
// port-level checker for the host data port, byte-port mode
// assumes it is bound to phdp_top; rst_n also clears the link domain
`timescale 1ns/1ns
module phdp_top_asserts (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       portRefClock,
  input wire logic       chipSelectN,
  input wire logic       readStrobeN,
  input wire logic       hostTxEnable,
  input wire logic [7:0] hostReadByte,
  input wire logic       hostDataBusOe,
  input wire logic       txInProgress,
  input wire logic       rxDataValid,
  input wire logic       statusOe,
  input wire logic [1:0] rmiiRxd,
  input wire logic [7:0] modemTxByte,
  input wire logic       modemTxValid,
  input wire logic       modemTxReady,
  input wire logic       modemRxValid,
  input wire logic       modemRxReady
);
  // pins pass two sync flops plus a register, so four samples settle them
  AST_OE_SEL: assert property (@(posedge portRefClock) disable iff (!rst_n)
    chipSelectN [*4] |=> !hostDataBusOe) else $error("bus driven while deselected");
  AST_OE_READ: assert property (@(posedge portRefClock) disable iff (!rst_n)
    readStrobeN [*4] |=> !hostDataBusOe) else $error("bus driven without read");
  AST_STATUS_FLOAT: assert property (@(posedge portRefClock) disable iff (!rst_n)
    chipSelectN [*4] |=> !statusOe) else $error("status pins driven while deselected");
  AST_TIP_RISE: assert property (@(posedge portRefClock) disable iff (!rst_n)
    $rose(hostTxEnable) && !txInProgress |-> ##[2:4] txInProgress)
    else $error("tx in progress did not follow enable");
  AST_TIP_FALL: assert property (@(posedge portRefClock) disable iff (!rst_n)
    $fell(txInProgress) |-> !hostTxEnable && !$past(hostTxEnable, 2))
    else $error("tx in progress fell while enable high");
  AST_RX_NOT_TX: assert property (@(posedge portRefClock) disable iff (!rst_n)
    $rose(rxDataValid) |-> !txInProgress) else $error("receive started during transmit");
  AST_READ_HOLD: assert property (@(posedge portRefClock) disable iff (!rst_n)
    (rxDataValid && readStrobeN) [*6] |=> $stable(hostReadByte))
    else $error("read byte moved without read edge");
  AST_DIBIT_HOLD: assert property (@(posedge portRefClock) disable iff (!rst_n)
    $rose(rxDataValid) |-> (rmiiRxd == phdp_pkg::DIBIT_IDLE) [*8])
    else $error("di-bits not idle after valid");
  AST_MODEM_ACK: assert property (@(posedge clk) disable iff (!rst_n)
    modemRxValid && modemRxReady |=> !modemRxReady) else $error("rx ready stayed up");
  AST_TX_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    modemTxValid && !modemTxReady |=> modemTxValid && $stable(modemTxByte))
    else $error("tx byte dropped before ready");
endmodule : phdp_top_asserts

// File: test/phdp_modem_model.sv
// modem-side stand-in: sinks transmit bytes, sources receive frames
// assumes the core clk domain and its synchronous reset
`timescale 1ns/1ns
module phdp_modem_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] modemTxByte,
  input  wire logic       modemTxLast,
  input  wire logic       modemTxValid,
  output logic            modemTxReady,
  output logic      [7:0] modemRxByte,
  output logic            modemRxLast,
  output logic            modemRxError,
  output logic            modemRxValid,
  input  wire logic       modemRxReady
);
  logic [7:0] txSeen[$];
  logic       txLast[$];
  logic       paceR;
  // ready every other cycle, so prompt and stalled answers both occur
  always_ff @(posedge clk) begin
    if (!rst_n) paceR <= 1'b0;
    else paceR <= ~paceR;
  end
  assign modemTxReady = paceR;
  // collect accepted bytes for the bench
  always @(posedge clk) begin
    if (rst_n && modemTxValid && modemTxReady) begin
      txSeen.push_back(modemTxByte);
      txLast.push_back(modemTxLast);
    end
  end
  initial begin
    modemRxByte = 8'h00;
    modemRxLast = 1'b0;
    modemRxError = 1'b0;
    modemRxValid = 1'b0;
  end
  // ready is registered, so high at a falling edge means taken at the next rise
  task send(input logic [7:0] d[$], input logic err);
    @(posedge clk) #1;
    for (int i = 0; i < d.size(); i++) begin
      modemRxByte = d[i];
      modemRxLast = (i == d.size() - 1);
      modemRxError = err && (i == d.size() - 1); // error rides on the closing byte only
      modemRxValid = 1'b1;
      @(negedge clk);
      while (!modemRxReady) @(negedge clk);
      @(posedge clk) #1;
    end
    modemRxValid = 1'b0;
    modemRxLast = 1'b0;
    modemRxByte = ~modemRxByte; // released lines show no stale byte
  endtask : send
endmodule : phdp_modem_model

// File: test/tb_top.sv
// self-checking bench for the host data port in byte-port and reduced-pin modes
// assumes phdp_top with default depths; modem side is a behavioural model
`timescale 1ns/1ns
module tb_top;
  logic       clk, portRefClock, rst_n, chipSelectN, readStrobeN, writeStrobeN;
  logic       hostTxEnable, hostDataBusOe, txInProgress, rxDataValid, rxErrorFlag;
  logic [7:0] hostDrv, hostWriteByte, hostReadByte, modemTxByte, modemRxByte;
  logic       modemTxValid, modemTxReady, modemRxLast, modemRxError, modemRxValid;
  logic       modemRxReady, rmiiTxEn, modemTxLast;
  logic [1:0] rmiiTxd, rmiiRxd;
  logic [2:0] modeStrap;
  int         mismatches, samplesChecked;
  // resolved bus: the device wins while it drives
  assign hostWriteByte = hostDataBusOe ? hostReadByte : hostDrv;
  phdp_top u_dut (.clk(clk), .rst_n(rst_n), .portRefClock(portRefClock),
    .modeStrap(modeStrap), .chipSelectN(chipSelectN), .readStrobeN(readStrobeN),
    .writeStrobeN(writeStrobeN), .hostTxEnable(hostTxEnable), .hostWriteByte(hostWriteByte),
    .hostReadByte(hostReadByte), .hostDataBusOe(hostDataBusOe), .txInProgress(txInProgress),
    .rxDataValid(rxDataValid), .rxErrorFlag(rxErrorFlag), .statusOe(), .rmiiTxd(rmiiTxd),
    .rmiiTxEn(rmiiTxEn), .rmiiRxd(rmiiRxd), .modemTxByte(modemTxByte),
    .modemTxLast(modemTxLast),
    .modemTxValid(modemTxValid), .modemTxReady(modemTxReady), .modemRxByte(modemRxByte),
    .modemRxLast(modemRxLast), .modemRxError(modemRxError), .modemRxValid(modemRxValid),
    .modemRxReady(modemRxReady));
  phdp_modem_model u_modem (.clk(clk), .rst_n(rst_n), .modemTxByte(modemTxByte),
    .modemTxLast(modemTxLast),
    .modemTxValid(modemTxValid), .modemTxReady(modemTxReady), .modemRxByte(modemRxByte),
    .modemRxLast(modemRxLast), .modemRxError(modemRxError), .modemRxValid(modemRxValid),
    .modemRxReady(modemRxReady));
  // core clock 8 ns, link clock 15 ns with its own phase
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    portRefClock = 1'b0;
    #3;
    forever begin
      #7 portRefClock = 1'b1;
      #8 portRefClock = 1'b0;
    end
  end
  task check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task endSim();
    $display("checks %0d mismatches %0d", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : endSim
  // one write strobe held low for lowCyc reference cycles
  task hwr(input logic [7:0] b, input int lowCyc);
    @(posedge portRefClock) #1;
    hostDrv = b;
    writeStrobeN = 1'b0;
    repeat (lowCyc) @(posedge portRefClock);
    #1 writeStrobeN = 1'b1;
    repeat (4) @(posedge portRefClock);
  endtask : hwr
  // one read strobe; byte and enable taken just before the rising edge
  task hrd(input logic cs, output logic [7:0] v, output logic o);
    @(posedge portRefClock) #1;
    chipSelectN = cs;
    readStrobeN = 1'b0;
    repeat (4) @(posedge portRefClock);
    #1 v = hostReadByte;
    o = hostDataBusOe;
    readStrobeN = 1'b1;
    repeat (4) @(posedge portRefClock);
    #1 chipSelectN = 1'b0;
  endtask : hrd
  task waitValid(input logic lvl);
    for (int i = 0; i < 400 && rxDataValid !== lvl; i++) @(posedge portRefClock) #1;
    check("rxDataValid", 8'(rxDataValid), 8'(lvl));
  endtask : waitValid
  task testTx();
    check("txIdleBeforeEn", 8'(txInProgress), 8'h00);
    @(posedge portRefClock) #1 hostTxEnable = 1'b1;
    repeat (5) @(posedge portRefClock);
    #1 check("txInProgress", 8'(txInProgress), 8'h01);
    hwr(8'ha5, 3);
    hwr(8'hff, 2); // too short, must be ignored
    hwr(8'h3c, 3);
    hwr(8'h0f, 4);
    @(posedge portRefClock) #1 hostTxEnable = 1'b0;
    for (int i = 0; i < 400 && txInProgress !== 1'b0; i++) @(posedge portRefClock);
    #1 check("txInProgress", 8'(txInProgress), 8'h00);
    check("txCount", 8'(u_modem.txSeen.size()), 8'h03);
    check("tx0", u_modem.txSeen[0], 8'ha5);
    check("tx1", u_modem.txSeen[1], 8'h3c);
    check("tx2", u_modem.txSeen[2], 8'h0f);
    check("txLast", 8'({u_modem.txLast[0], u_modem.txLast[1], u_modem.txLast[2]}), 8'h01);
    $display("test tx done");
  endtask : testTx
  task testRx();
    logic [7:0] v;
    logic       o;
    u_modem.send({8'h11, 8'h22, 8'h33}, 1'b0);
    waitValid(1'b1);
    check("rxErrorFlag", 8'(rxErrorFlag), 8'h00);
    hrd(1'b1, v, o);
    check("busOeDeselected", 8'(o), 8'h00);
    hrd(1'b0, v, o);
    check("lenMsb", v, 8'h00);
    check("busOe", 8'(o), 8'h01);
    hrd(1'b0, v, o);
    check("lenLsb", v, 8'h03);
    for (int i = 0; i < 3; i++) begin
      hrd(1'b0, v, o);
      check("payload", v, 8'(8'h11 * (i + 1)));
    end
    check("rxDataValid", 8'(rxDataValid), 8'h00);
    $display("test rx done");
  endtask : testRx
  task testErrTx();
    logic [7:0] v;
    logic       o;
    u_modem.send({8'h5a}, 1'b1);
    @(posedge portRefClock) #1 hostTxEnable = 1'b1;
    hwr(8'h77, 3);
    repeat (40) @(posedge portRefClock);
    #1 check("rxDuringTx", 8'(rxDataValid), 8'h00);
    hostTxEnable = 1'b0;
    waitValid(1'b1);
    check("rxErrorFlag", 8'(rxErrorFlag), 8'h01);
    check("txDuringRx", u_modem.txSeen[3], 8'h77);
    check("txLast3", 8'(u_modem.txLast[3]), 8'h01);
    hrd(1'b0, v, o);
    check("lenMsb", v, 8'h00);
    hrd(1'b0, v, o);
    check("lenLsb", v, 8'h01);
    hrd(1'b0, v, o);
    check("payload", v, 8'h5a);
    waitValid(1'b0);
    check("rxDataValid", 8'(rxDataValid), 8'h00);
    $display("test error and priority done");
  endtask : testErrTx
  // reduced-pin mode after a second reset: errored receive, then a transmit
  task testRmii();
    logic [7:0] e;
    int         k;
    @(posedge clk) #1;
    rst_n = 1'b0;
    modeStrap = phdp_pkg::MODE_RMII;
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (12) @(posedge portRefClock);
    u_modem.send({8'h4b, 8'hc6}, 1'b1);
    waitValid(1'b1);
    for (int j = 0; j < phdp_pkg::DECODE_HOLD_CYC + 9; j++) begin
      k = j - phdp_pkg::DECODE_HOLD_CYC - 1;
      if (k < 0) e = 8'(phdp_pkg::DIBIT_IDLE);
      else if (k < 4) e = (8'h4b >> (2 * k)) & 8'h03;
      else e = 8'(phdp_pkg::DIBIT_ERR);
      check("rmiiRxd", 8'(rmiiRxd), e);
      @(posedge portRefClock) #1;
    end
    waitValid(1'b0);
    rmiiTxEn = 1'b1;
    for (int j = 0; j < 8; j++) begin
      rmiiTxd = 2'(16'hc35a >> (2 * j));
      @(posedge portRefClock) #1;
    end
    check("txInProgress", 8'(txInProgress), 8'h01);
    rmiiTxEn = 1'b0;
    rmiiTxd = 2'h0;
    for (int i = 0; i < 400 && txInProgress !== 1'b0; i++) @(posedge portRefClock);
    #1 check("txInProgress", 8'(txInProgress), 8'h00);
    check("txCount", 8'(u_modem.txSeen.size()), 8'h06);
    check("tx4", u_modem.txSeen[4], 8'h5a);
    check("tx5", u_modem.txSeen[5], 8'hc3);
    check("txLast", 8'({u_modem.txLast[4], u_modem.txLast[5]}), 8'h01);
    $display("test reduced-pin done");
  endtask : testRmii
  // reset spans enough edges of both clocks for the link-side reset
  initial begin
    rst_n = 1'b0;
    chipSelectN = 1'b0;
    readStrobeN = 1'b1;
    writeStrobeN = 1'b1;
    hostTxEnable = 1'b0;
    hostDrv = 8'h00;
    modeStrap = phdp_pkg::MODE_FIFO;
    rmiiTxEn = 1'b0;
    rmiiTxd = 2'h0;
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (12) @(posedge portRefClock);
    testTx();
    testRx();
    testErrTx();
    testRmii();
    endSim();
  end
  // watchdog well past the expected run of a few microseconds
  initial begin
    #200000;
    mismatches++;
    endSim();
  end
endmodule : tb_top
bind phdp_top phdp_top_asserts u_chk (.clk, .rst_n, .portRefClock, .chipSelectN,
  .readStrobeN, .hostTxEnable, .hostReadByte, .hostDataBusOe, .txInProgress, .rxDataValid,
  .statusOe, .rmiiRxd, .modemTxByte, .modemTxValid, .modemTxReady, .modemRxValid,
  .modemRxReady);
